// >>> rtl/crf_core_regs.sv
// Architectural register set of the 8-bit core
//
// Behaviour
// - Program counter is 16 bits, unpaged.
// - Core registers change only by instructions.
// - Accumulator takes logical and arithmetic results.
// - Index register supplies indexed offset.
// - Stack pointer moves on stack instructions.
// - Exchange and add may load stack pointer.
// - Flags bit layout: IE, zero, carry, super, bank.
// - Software cannot change supervisory bit.
// - ALU operations update selected flags.
// - Software sets flags by OR, clears by AND.
// - Bank bit selects register bank.
// - Super bit shows supervisor execution.
// - Carry bit records previous carry.
// - Zero bit records previous zero result.
// - Global enable gates all interrupts.
// - Flags readable at fixed register address.
// - Program counter high holds bits 15-8.
// - Upper register space needs bank bit.
`timescale 1ns/10ps
module crf_core_regs
  import crf_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Accumulator and index writes from execution
  input wire logic acc_we_in,
  input wire logic [7:0] acc_wdata_in,
  input wire logic idx_we_in,
  input wire logic [7:0] idx_wdata_in,
  // Stack pointer control
  input wire crf_spop_t sp_op_in,
  input wire logic [7:0] sp_wdata_in,
  // Program counter control
  input wire logic pc_inc_in,
  input wire logic pc_load_in,
  input wire logic [15:0] pc_wdata_in,
  // Flags control
  input wire crf_fop_t fop_in,
  input wire logic [7:0] fimm_in,
  input wire logic alu_upd_in,
  input wire logic [7:0] alu_upd_mask_in,
  input wire logic alu_zero_in,
  input wire logic alu_carry_in,
  input wire logic super_set_in,
  input wire logic super_clr_in,
  // Register space access from execution
  input wire logic [8:0] rs_addr_in,
  input wire logic rs_req_in,
  input wire logic [7:0] rs_ext_rdata_in,
  output logic rs_ext_sel_out,
  output logic rs_flags_hit_out,
  output logic [7:0] rs_rdata_out,
  // Interrupt gating
  input wire logic irq_pending_in,
  output logic irq_take_out,
  // Register values
  output logic [7:0] acc_out,
  output logic [7:0] idx_out,
  output logic [7:0] sp_out,
  output logic [7:0] pch_out,
  output logic [7:0] pcl_out,
  output logic [15:0] pc_out,
  output logic [7:0] flags_out,
  output logic bank_select_bit_out
);
  ////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] accumulator;
    logic [7:0] index;
    logic [7:0] stack_top_pointer;
    logic [CRF_PC_WIDTH-1:0] program_counter;
  } crf_st_t;

  crf_st_t st_q;
  crf_st_t st_d;
  logic [7:0] flags_w;

  // Next stack pointer for the selected stack operation
  function automatic logic [7:0] crf_next_sp(input crf_spop_t op,
                                             input logic [7:0] sp,
                                             input logic [7:0] wd);
    logic [7:0] r;
    r = sp;
    case (op)
      CRF_SP_INC: r = sp + 8'h01;
      CRF_SP_DEC: r = sp - 8'h01;
      CRF_SP_ADD: r = sp + wd;
      CRF_SP_LOAD: r = wd;
      default: r = sp;
    endcase
    return r;
  endfunction

  crf_flags u_flags (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .fop_in(fop_in),
    .fimm_in(fimm_in),
    .alu_upd_in(alu_upd_in),
    .alu_upd_mask_in(alu_upd_mask_in),
    .alu_zero_in(alu_zero_in),
    .alu_carry_in(alu_carry_in),
    .super_set_in(super_set_in),
    .super_clr_in(super_clr_in),
    .flags_out(flags_w)
  );

  ////////////////////////////////////////////////////////////////////
  // No register-space write path exists, so only instructions move them
  always_comb
  begin
    st_d = st_q;
    if (acc_we_in)
    begin
      st_d.accumulator = acc_wdata_in;
    end
    if (idx_we_in)
    begin
      st_d.index = idx_wdata_in;
    end
    st_d.stack_top_pointer = crf_next_sp(sp_op_in, st_q.stack_top_pointer,
                                         sp_wdata_in);
    // Load wins over increment so jumps and calls are never lost
    if (pc_load_in)
    begin
      st_d.program_counter = pc_wdata_in;
    end
    else if (pc_inc_in)
    begin
      st_d.program_counter = st_q.program_counter + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_q.accumulator <= CRF_BYTE_RESET;
      st_q.index <= CRF_BYTE_RESET;
      st_q.stack_top_pointer <= CRF_BYTE_RESET;
      st_q.program_counter <= CRF_PC_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register space decode
  logic upper_w;
  assign upper_w = rs_addr_in > CRF_LOW_SPACE_TOP;
  assign bank_select_bit_out = flags_w[CRF_BIT_BANK];
  // Upper space is unreachable with the bank bit clear
  assign rs_ext_sel_out = rs_req_in &&
                          (!upper_w || flags_w[CRF_BIT_BANK]);
  // Of the core registers, only the flags appear in the register space
  assign rs_flags_hit_out = rs_req_in &&
                            rs_addr_in == CRF_FLAGS_ADDR;
  assign rs_rdata_out = rs_flags_hit_out ? flags_w :
                        (rs_ext_sel_out ? rs_ext_rdata_in : 8'h00);

  assign irq_take_out = irq_pending_in && flags_w[CRF_BIT_IE];

  assign acc_out = st_q.accumulator;
  assign idx_out = st_q.index;
  assign sp_out = st_q.stack_top_pointer;
  assign pc_out = st_q.program_counter;
  assign pch_out = st_q.program_counter[15:8];
  assign pcl_out = st_q.program_counter[7:0];
  assign flags_out = flags_w;

  ////////////////////////////////////////////////////////////////////
  property p_acc_hold;
    @(posedge mclk_in) disable iff (!nrst_in)
      !acc_we_in |=> acc_out == $past(acc_out);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("Accumulator changed without a write");

  property p_acc_load;
    @(posedge mclk_in) disable iff (!nrst_in)
      acc_we_in |=> acc_out == $past(acc_wdata_in);
  endproperty
  a_acc_load: assert property (p_acc_load)
    else $error("Accumulator missed result");

  property p_sp_push;
    @(posedge mclk_in) disable iff (!nrst_in)
      sp_op_in == CRF_SP_INC |=> sp_out == $past(sp_out) + 8'h01;
  endproperty
  a_sp_push: assert property (p_sp_push)
    else $error("Stack pointer did not advance");

  property p_sp_add;
    @(posedge mclk_in) disable iff (!nrst_in)
      sp_op_in == CRF_SP_ADD |=>
        sp_out == 8'($past(sp_out) + $past(sp_wdata_in));
  endproperty
  a_sp_add: assert property (p_sp_add)
    else $error("Stack pointer add wrong");

  property p_pc_inc;
    @(posedge mclk_in) disable iff (!nrst_in)
      (pc_inc_in && !pc_load_in) |=> pc_out == $past(pc_out) + 16'h0001;
  endproperty
  a_pc_inc: assert property (p_pc_inc)
    else $error("Program counter did not increment");

  property p_pch_bits;
    @(posedge mclk_in) disable iff (!nrst_in)
      pc_load_in |=> {pch_out, pcl_out} == $past(pc_wdata_in);
  endproperty
  a_pch_bits: assert property (p_pch_bits)
    else $error("Program counter bytes misplaced");

  property p_bank_gate;
    @(posedge mclk_in) disable iff (!nrst_in)
      (rs_req_in && rs_addr_in > 9'h0ff && !flags_out[4]) |->
        !rs_ext_sel_out;
  endproperty
  a_bank_gate: assert property (p_bank_gate)
    else $error("Upper space reached with bank bit clear");

  property p_ie_gate;
    @(posedge mclk_in) disable iff (!nrst_in)
      !flags_out[0] |-> !irq_take_out;
  endproperty
  a_ie_gate: assert property (p_ie_gate)
    else $error("Interrupt taken while disabled");

  property p_flags_read;
    @(posedge mclk_in) disable iff (!nrst_in)
      (rs_req_in && rs_addr_in == 9'h0f7) |-> rs_rdata_out == flags_out;
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("Flags read returned wrong value");

  property p_idx_load;
    @(posedge mclk_in) disable iff (!nrst_in)
      idx_we_in |=> idx_out == $past(idx_wdata_in);
  endproperty
  a_idx_load: assert property (p_idx_load)
    else $error("Index register missed its load");

  property p_idx_hold;
    @(posedge mclk_in) disable iff (!nrst_in)
      !idx_we_in |=> idx_out == $past(idx_out);
  endproperty
  a_idx_hold: assert property (p_idx_hold)
    else $error("Index register changed without a write");

  property p_sp_pop;
    @(posedge mclk_in) disable iff (!nrst_in)
      sp_op_in == CRF_SP_DEC |=> sp_out == $past(sp_out) - 8'h01;
  endproperty
  a_sp_pop: assert property (p_sp_pop)
    else $error("Stack pointer did not step back");

  property p_sp_load;
    @(posedge mclk_in) disable iff (!nrst_in)
      sp_op_in == CRF_SP_LOAD |=> sp_out == $past(sp_wdata_in);
  endproperty
  a_sp_load: assert property (p_sp_load)
    else $error("Stack pointer load wrong");

  property p_sp_hold;
    @(posedge mclk_in) disable iff (!nrst_in)
      sp_op_in == CRF_SP_HOLD |=> sp_out == $past(sp_out);
  endproperty
  a_sp_hold: assert property (p_sp_hold)
    else $error("Stack pointer moved without an operation");

  property p_pc_hold;
    @(posedge mclk_in) disable iff (!nrst_in)
      (!pc_inc_in && !pc_load_in) |=> pc_out == $past(pc_out);
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("Program counter moved without a request");

  property p_pc_pair;
    @(posedge mclk_in) disable iff (!nrst_in)
      pc_out == {pch_out, pcl_out};
  endproperty
  a_pc_pair: assert property (p_pc_pair)
    else $error("Program counter bytes disagree with the whole");

  property p_ext_low;
    @(posedge mclk_in) disable iff (!nrst_in)
      (rs_req_in && rs_addr_in <= 9'h0ff) |-> rs_ext_sel_out;
  endproperty
  a_ext_low: assert property (p_ext_low)
    else $error("Lower register space not reachable");

  property p_rd_quiet;
    @(posedge mclk_in) disable iff (!nrst_in)
      (rs_req_in && !rs_ext_sel_out && !rs_flags_hit_out) |->
        rs_rdata_out == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("Refused access returned data");

  property p_ie_pass;
    @(posedge mclk_in) disable iff (!nrst_in)
      (irq_pending_in && flags_out[0]) |-> irq_take_out;
  endproperty
  a_ie_pass: assert property (p_ie_pass)
    else $error("Enabled interrupt not taken");

  property p_bank_out;
    @(posedge mclk_in) disable iff (!nrst_in)
      bank_select_bit_out == flags_out[4];
  endproperty
  a_bank_out: assert property (p_bank_out)
    else $error("Bank select output differs from flags");
endmodule

// >>> rtl/crf_flags.sv
// Flags register with logical update, ALU update and supervisory state
`timescale 1ns/10ps
module crf_flags
  import crf_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Software logical update
  input wire crf_fop_t fop_in,
  input wire logic [7:0] fimm_in,
  // ALU result flags
  input wire logic alu_upd_in,
  input wire logic [7:0] alu_upd_mask_in,
  input wire logic alu_zero_in,
  input wire logic alu_carry_in,
  // Supervisory state
  input wire logic super_set_in,
  input wire logic super_clr_in,
  // Value
  output logic [7:0] flags_out
);
  typedef struct packed {
    logic [7:0] flags;
  } crf_flags_st_t;

  crf_flags_st_t st_q;
  crf_flags_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    // Logical instruction has priority over ALU effects in the same cycle
    if (fop_in == CRF_FOP_OR)
    begin
      st_d.flags = st_q.flags | (fimm_in & CRF_FLAGS_SW_MASK);
    end
    else if (fop_in == CRF_FOP_AND)
    begin
      st_d.flags = st_q.flags & (fimm_in | ~CRF_FLAGS_SW_MASK);
    end
    else if (alu_upd_in)
    begin
      // Only the flags that the instruction names are touched
      if (alu_upd_mask_in[CRF_BIT_ZERO])
      begin
        st_d.flags[CRF_BIT_ZERO] = alu_zero_in;
      end
      if (alu_upd_mask_in[CRF_BIT_CARRY])
      begin
        st_d.flags[CRF_BIT_CARRY] = alu_carry_in;
      end
    end
    // Super follows the core's mode, never software
    if (super_set_in)
    begin
      st_d.flags[CRF_BIT_SUPER] = 1'b1;
    end
    else if (super_clr_in)
    begin
      st_d.flags[CRF_BIT_SUPER] = 1'b0;
    end
    st_d.flags[7:5] = 3'h0;
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_q.flags <= CRF_FLAGS_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign flags_out = st_q.flags;

  property p_super_locked;
    @(posedge mclk_in) disable iff (!nrst_in)
      (!super_set_in && !super_clr_in) |=>
        flags_out[CRF_BIT_SUPER] == $past(flags_out[CRF_BIT_SUPER]);
  endproperty
  a_super_locked: assert property (p_super_locked)
    else $error("Super bit changed without core mode change");

  property p_reserved_zero;
    @(posedge mclk_in) disable iff (!nrst_in)
      flags_out[7:5] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved flag bits not zero");

  property p_or_sets;
    @(posedge mclk_in) disable iff (!nrst_in)
      (fop_in == CRF_FOP_OR) |=>
        ((flags_out & $past(fimm_in) & CRF_FLAGS_SW_MASK & 8'he7) ==
         ($past(fimm_in) & CRF_FLAGS_SW_MASK & 8'he7));
  endproperty
  a_or_sets: assert property (p_or_sets)
    else $error("OR to flags did not set bits");

  property p_alu_zero;
    @(posedge mclk_in) disable iff (!nrst_in)
      (fop_in == CRF_FOP_NONE && alu_upd_in && alu_upd_mask_in[1]) |=>
        flags_out[CRF_BIT_ZERO] == $past(alu_zero_in);
  endproperty
  a_alu_zero: assert property (p_alu_zero)
    else $error("Zero flag not taken from ALU");

  property p_alu_carry;
    @(posedge mclk_in) disable iff (!nrst_in)
      (fop_in == CRF_FOP_NONE && alu_upd_in && alu_upd_mask_in[2]) |=>
        flags_out[CRF_BIT_CARRY] == $past(alu_carry_in);
  endproperty
  a_alu_carry: assert property (p_alu_carry)
    else $error("Carry flag not taken from ALU");
endmodule

// >>> rtl/crf_pkg.sv
// Package of constants and types for the core register file
package crf_pkg;
  localparam logic [8:0] CRF_FLAGS_ADDR = 9'h0f7;
  localparam logic [8:0] CRF_LOW_SPACE_TOP = 9'h0ff;
  localparam int CRF_PC_WIDTH = 16;
  localparam int CRF_BIT_IE = 0;
  localparam int CRF_BIT_ZERO = 1;
  localparam int CRF_BIT_CARRY = 2;
  localparam int CRF_BIT_SUPER = 3;
  localparam int CRF_BIT_BANK = 4;
  localparam logic [7:0] CRF_FLAGS_RESET = 8'h02;
  localparam logic [7:0] CRF_FLAGS_SW_MASK = 8'h17;
  localparam logic [7:0] CRF_FLAGS_ALU_MASK = 8'h06;
  localparam logic [7:0] CRF_BYTE_RESET = 8'h00;
  localparam logic [15:0] CRF_PC_RESET = 16'h0000;

  // Logical operation applied by software to the flags
  typedef enum logic [1:0] {
    CRF_FOP_NONE,
    CRF_FOP_OR,
    CRF_FOP_AND
  } crf_fop_t;

  // Selects which source writes the stack pointer
  typedef enum logic [2:0] {
    CRF_SP_HOLD,
    CRF_SP_INC,
    CRF_SP_DEC,
    CRF_SP_ADD,
    CRF_SP_LOAD
  } crf_spop_t;
endpackage

// >>> verification/crf_ext_regs_model.sv
// Model of the external registers that answer register-space reads
`timescale 1ns/10ps
module crf_ext_regs_model
(
  // Access
  input wire logic [8:0] addr_in,
  input wire logic sel_in,
  // Read data
  output logic [7:0] rdata_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Unselected reads show the inverse pattern, so a leaked value is visible
  assign rdata_out = sel_in ? (addr_in[7:0] ^ 8'ha5)
                            : ~(addr_in[7:0] ^ 8'ha5);
endmodule

// >>> verification/tb_top.sv
// Self-checking testbench for the core register file
`timescale 1ns/10ps
module tb_top
  import crf_pkg::*;
;
  logic mclk_in, nrst_in, acc_we, idx_we, pc_inc, pc_load, upd, az, ac;
  logic ss, sc, rs_req, irq_p, sel, hit, take, bank;
  logic [7:0] acc_wd, idx_wd, sp_wd, fimm, am, ext_rd;
  logic [7:0] rd, acc, idx, sp, pch, pcl, flags;
  logic [15:0] pc_wd, pc;
  logic [8:0] rs_addr;
  crf_spop_t sp_op;
  crf_fop_t fop;
  int n_errors, n_compared;
  crf_spop_t ops[6] = '{CRF_SP_LOAD, CRF_SP_INC, CRF_SP_INC, CRF_SP_DEC,
                        CRF_SP_ADD, CRF_SP_HOLD};
  logic [7:0] spw[6] = '{8'hfe, 8'h00, 8'h00, 8'h00, 8'h03, 8'h40};
  logic [7:0] spe[6] = '{8'hfe, 8'hff, 8'h00, 8'hff, 8'h02, 8'h02};
  ////////////////////////////////////////////////////////////////////////////
  crf_core_regs DUT (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .acc_we_in(acc_we), .acc_wdata_in(acc_wd), .idx_we_in(idx_we),
    .idx_wdata_in(idx_wd), .sp_op_in(sp_op), .sp_wdata_in(sp_wd),
    .pc_inc_in(pc_inc), .pc_load_in(pc_load), .pc_wdata_in(pc_wd),
    .fop_in(fop), .fimm_in(fimm), .alu_upd_in(upd), .alu_upd_mask_in(am),
    .alu_zero_in(az), .alu_carry_in(ac), .super_set_in(ss),
    .super_clr_in(sc), .rs_addr_in(rs_addr), .rs_req_in(rs_req),
    .rs_ext_rdata_in(ext_rd), .rs_ext_sel_out(sel), .rs_flags_hit_out(hit),
    .rs_rdata_out(rd), .irq_pending_in(irq_p), .irq_take_out(take),
    .acc_out(acc), .idx_out(idx), .sp_out(sp), .pch_out(pch), .pcl_out(pcl),
    .pc_out(pc), .flags_out(flags), .bank_select_bit_out(bank));
  crf_ext_regs_model EXT (.addr_in(rs_addr), .sel_in(sel),
    .rdata_out(ext_rd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs change 2 ns after the edge, so each check sees settled outputs
  task automatic cyc();
    @(posedge mclk_in);
    #2;
  endtask
  task automatic step_f(input crf_fop_t op, input logic [7:0] imm, m,
                        input logic u, z, c, s, r, input logic [7:0] e);
    fop = op;
    fimm = imm;
    am = m;
    upd = u;
    az = z;
    ac = c;
    ss = s;
    sc = r;
    cyc();
    chk("flags", {8'h00, flags}, {8'h00, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    chk("acc", {8'h00, acc}, 16'h0000);
    chk("idx", {8'h00, idx}, 16'h0000);
    chk("sp", {8'h00, sp}, 16'h0000);
    chk("pc", pc, CRF_PC_RESET);
    chk("flags", {8'h00, flags}, 16'h0002);
  endtask
  task automatic t_acc_idx();
    acc_we = 1'b1;
    acc_wd = 8'h5a;
    idx_we = 1'b1;
    idx_wd = 8'hc3;
    cyc();
    acc_we = 1'b0;
    idx_we = 1'b0;
    acc_wd = 8'h11;
    idx_wd = 8'h22;
    chk("acc", {8'h00, acc}, 16'h005a);
    chk("idx", {8'h00, idx}, 16'h00c3);
    cyc();
    chk("acc_hold", {8'h00, acc}, 16'h005a);
  endtask
  task automatic t_sp();
    for (int i = 0; i < 6; i++)
    begin
      sp_op = ops[i];
      sp_wd = spw[i];
      cyc();
      chk("sp", {8'h00, sp}, {8'h00, spe[i]});
    end
  endtask
  task automatic t_pc();
    pc_load = 1'b1;
    pc_inc = 1'b1;
    pc_wd = 16'h12ff;
    cyc();
    chk("pc_load", pc, 16'h12ff);
    pc_load = 1'b0;
    cyc();
    chk("pch", {8'h00, pch}, 16'h0013);
    chk("pcl", {8'h00, pcl}, 16'h0000);
    pc_load = 1'b1;
    pc_inc = 1'b0;
    pc_wd = 16'hffff;
    cyc();
    pc_load = 1'b0;
    pc_inc = 1'b1;
    cyc();
    pc_inc = 1'b0;
    chk("pc_wrap", pc, 16'h0000);
  endtask
  task automatic t_flags();
    step_f(CRF_FOP_AND, 8'h00, 8'h00, 0, 0, 0, 0, 0, 8'h00);
    step_f(CRF_FOP_OR, 8'hff, 8'h00, 0, 0, 0, 0, 0, 8'h17);
    chk("bank", {15'h0000, bank}, 16'h0001);
    step_f(CRF_FOP_AND, 8'h00, 8'h06, 1, 1, 1, 0, 0, 8'h00);
    step_f(CRF_FOP_NONE, 8'h00, 8'h04, 1, 1, 1, 0, 0, 8'h04);
    step_f(CRF_FOP_NONE, 8'h00, 8'h06, 1, 1, 0, 0, 0, 8'h02);
    step_f(CRF_FOP_NONE, 8'h00, 8'h00, 0, 0, 0, 1, 1, 8'h0a);
    step_f(CRF_FOP_AND, 8'h00, 8'h00, 0, 0, 0, 0, 0, 8'h08);
    step_f(CRF_FOP_NONE, 8'h00, 8'h00, 0, 0, 0, 0, 1, 8'h00);
  endtask
  task automatic t_irq_space();
    irq_p = 1'b1;
    cyc();
    chk("irq_off", {15'h0000, take}, 16'h0000);
    step_f(CRF_FOP_OR, 8'h01, 8'h00, 0, 0, 0, 0, 0, 8'h01);
    rs_req = 1'b1;
    rs_addr = CRF_FLAGS_ADDR;
    cyc();
    chk("irq_on", {15'h0000, take}, 16'h0001);
    chk("hit", {15'h0000, hit}, 16'h0001);
    chk("rd_flags", {8'h00, rd}, 16'h0001);
    rs_addr = 9'h1e0;
    cyc();
    chk("sel_b0", {15'h0000, sel}, 16'h0000);
    chk("rd_b0", {8'h00, rd}, 16'h0000);
    rs_addr = CRF_LOW_SPACE_TOP;
    cyc();
    chk("rd_low", {8'h00, rd}, 16'h005a);
    rs_addr = 9'h1e0;
    step_f(CRF_FOP_OR, 8'h10, 8'h00, 0, 0, 0, 0, 0, 8'h11);
    chk("sel_b1", {15'h0000, sel}, 16'h0001);
    chk("rd_b1", {8'h00, rd}, 16'h0045);
    chk("hit_off", {15'h0000, hit}, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  // Nothing waits on a handshake, so one cycle bound guards the whole run
  initial
  begin
    repeat (5000) @(posedge mclk_in);
    n_errors++;
    finish_test();
  end
  initial
  begin
    {acc_we, idx_we, pc_inc, pc_load, upd, az, ac, ss, sc} = '0;
    {acc_wd, idx_wd, sp_wd, fimm, am} = '0;
    {rs_req, irq_p, rs_addr, pc_wd} = '0;
    sp_op = CRF_SP_HOLD;
    fop = CRF_FOP_NONE;
    n_errors = 0;
    n_compared = 0;
    nrst_in = 1'b0;
    repeat (16) @(posedge mclk_in);
    #2;
    nrst_in = 1'b1;
    t_reset_vals();
    t_acc_idx();
    t_sp();
    t_pc();
    t_flags();
    t_irq_space();
    nrst_in = 1'b0;
    #5;
    t_reset_vals();
    finish_test();
  end
endmodule
